// >>> hdl/nvsp_regs.svh
`ifndef NVSP_REGS_SVH
`define NVSP_REGS_SVH

// array geometry: 8 blocks of 512 rows, 8 columns per row
`define NVSP_ADDR_W       15
`define NVSP_DATA_W       8
`define NVSP_COL_W        3
`define NVSP_ROW_LSB      3
`define NVSP_ROW_W        12

// timer width, clock period
`define NVSP_CNT_W        8
`define NVSP_CLK_NS       40

// pin levels after reset: everything deasserted
`define NVSP_PIN_RST      1'b1
`define NVSP_DATA_RST     8'h00

// least times in ns; plain defaults, set them to the fitted part's figures
`define NVSP_T_CE_ACC_NS  100
`define NVSP_T_AA_NS      120
`define NVSP_T_PAGE_ACC_NS 60
`define NVSP_T_PC_NS      100
`define NVSP_T_RC_NS      200
`define NVSP_T_WC_NS      200
// page mode rate ceiling
`define NVSP_PAGE_HZ      15000000
`define NVSP_T_PAGE_CYC_NS ((1000000000 + `NVSP_PAGE_HZ - 1) / `NVSP_PAGE_HZ)

// least times round up to whole clock cycles
`define NVSP_CYC(ns)      (((ns) + `NVSP_CLK_NS - 1) / `NVSP_CLK_NS)
`define NVSP_CE_ACC_CYC   `NVSP_CYC(`NVSP_T_CE_ACC_NS)
`define NVSP_AA_CYC       `NVSP_CYC(`NVSP_T_AA_NS)
`define NVSP_PAGE_ACC_CYC `NVSP_CYC(`NVSP_T_PAGE_ACC_NS)
`define NVSP_PC_CYC       `NVSP_CYC(`NVSP_T_PC_NS)
`define NVSP_RC_CYC       `NVSP_CYC(`NVSP_T_RC_NS)
`define NVSP_WC_CYC       `NVSP_CYC(`NVSP_T_WC_NS)
`define NVSP_PAGE_CYC     `NVSP_CYC(`NVSP_T_PAGE_CYC_NS)

`endif

// >>> hdl/nvsp_pkg.sv
`include "nvsp_regs.svh"
package nvsp_pkg;

   typedef logic [`NVSP_ADDR_W-1:0] nvsp_addr_t;
   typedef logic [`NVSP_DATA_W-1:0] nvsp_data_t;
   typedef logic [`NVSP_ROW_W-1:0]  nvsp_row_t;
   typedef logic [`NVSP_CNT_W-1:0]  nvsp_cnt_t;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_RD_WAIT,
      ST_WR_ARM,
      ST_WR_LOW,
      ST_WR_END,
      ST_HOLD,
      ST_SEL,
      ST_PRE,
      ST_CEW_ARM,
      ST_CEW_LOW,
      ST_CEW_END
   } nvsp_state_t;

endpackage

// >>> hdl/nvsp_tmr_if.sv
`timescale 1ns/1ps
`include "nvsp_regs.svh"
interface nvsp_tmr_if;
   logic                   load;
   logic [`NVSP_CNT_W-1:0] count;
   logic                   done;

   modport ctl (output load, output count, input done);
   modport tmr (input load, input count, output done);
endinterface

// >>> hdl/nvsp_timer.sv
`timescale 1ns/1ps
`include "nvsp_regs.svh"
module nvsp_timer
   import nvsp_pkg::*;
(
   // clock and reset
   input  wire logic clock,
   input  wire logic nrst,
   // load and done
   nvsp_tmr_if.tmr   tmr
);

   nvsp_cnt_t count_reg;
   nvsp_cnt_t count_next;

   // a load of n raises done n edges later; a reload restarts the wait
   always_comb begin
      count_next = count_reg;
      if (tmr.load) begin
         count_next = tmr.count;
      end else if (count_reg != '0) begin
         count_next = count_reg - nvsp_cnt_t'(1);
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

   assign tmr.done = (count_reg == '0);

endmodule

// >>> hdl/nvsp_host.sv
`timescale 1ns/1ps
`include "nvsp_regs.svh"
// Function
// - host meets access time and holds data up to the terminating edge.
// - host gives one separate strobe pulse per written byte.
// - later strobe pulses with new columns write the open row.
// - chip select high starts pre-charge; host keeps it high long enough.
// - host spaces random addresses by the read or write cycle time.
// - host keeps strobe high around power transitions, and chip select high as well.
// - without cmd_keep, host asserts chip select only during accesses for lowest power.
module nvsp_host
   import nvsp_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       nrst,
   // command port
   input  wire logic       cmd_valid,
   input  wire logic       cmd_write,
   input  wire logic       cmd_ce_write,
   input  wire logic       cmd_keep,
   input  wire logic       cmd_release,
   input  wire nvsp_addr_t cmd_addr,
   input  wire nvsp_data_t cmd_wdata,
   output logic            cmd_ready,
   // results
   output logic            rd_valid,
   output nvsp_data_t      rd_data,
   output logic            wr_done,
   // memory pins
   output logic            chip_select_n,
   output logic            write_strobe_n,
   output logic            output_drive_n,
   output nvsp_addr_t      mem_addr,
   input  wire nvsp_data_t data_lines_in,
   output nvsp_data_t      data_lines_out,
   output logic            data_lines_oe
);

   nvsp_state_t state_reg;
   nvsp_state_t state_next;
   logic        cs_n_reg;
   logic        cs_n_next;
   logic        we_n_reg;
   logic        we_n_next;
   logic        oe_n_reg;
   logic        oe_n_next;
   nvsp_addr_t  addr_reg;
   nvsp_addr_t  addr_next;
   nvsp_data_t  dq_out_reg;
   nvsp_data_t  dq_out_next;
   logic        dq_oe_reg;
   logic        dq_oe_next;
   logic        ready_reg;
   logic        ready_next;
   logic        rd_valid_reg;
   logic        rd_valid_next;
   nvsp_data_t  rd_data_reg;
   nvsp_data_t  rd_data_next;
   logic        wr_done_reg;
   logic        wr_done_next;
   logic        keep_reg;
   logic        keep_next;
   nvsp_row_t   row_reg;
   nvsp_row_t   row_next;
   nvsp_cnt_t   acc_cnt_reg;
   nvsp_cnt_t   acc_cnt_next;
   logic        take;
   logic        same_row;
   nvsp_cnt_t   hit_acc;
   nvsp_cnt_t   hit_cyc;

   // access/pre-charge timer and cycle-spacing timer
   nvsp_tmr_if acc_if ();
   nvsp_tmr_if cyc_if ();

   nvsp_timer u_acc_timer (
      .clock (clock),
      .nrst  (nrst),
      .tmr   (acc_if.tmr)
   );

   nvsp_timer u_cyc_timer (
      .clock (clock),
      .nrst  (nrst),
      .tmr   (cyc_if.tmr)
   );

   assign take     = cmd_valid && ready_reg;
   // row compare against the latched row decides page hit or reopen
   assign same_row = (cmd_addr[`NVSP_ADDR_W-1:`NVSP_ROW_LSB] == row_reg);
   // page hit keeps the row open; a row change pays the address access time
   assign hit_acc  = same_row ? `NVSP_CNT_W'(`NVSP_PAGE_ACC_CYC)
                              : `NVSP_CNT_W'(`NVSP_AA_CYC);
   // page accesses never faster than the page rate ceiling
   assign hit_cyc  = same_row ? `NVSP_CNT_W'(`NVSP_PAGE_CYC)
                   : (cmd_write ? `NVSP_CNT_W'(`NVSP_WC_CYC)
                                : `NVSP_CNT_W'(`NVSP_RC_CYC));

   always_comb begin
      state_next    = state_reg;
      cs_n_next     = cs_n_reg;
      we_n_next     = we_n_reg;
      oe_n_next     = oe_n_reg;
      addr_next     = addr_reg;
      dq_out_next   = dq_out_reg;
      dq_oe_next    = dq_oe_reg;
      rd_data_next  = rd_data_reg;
      keep_next     = keep_reg;
      row_next      = row_reg;
      acc_cnt_next  = acc_cnt_reg;
      rd_valid_next = 1'b0;
      wr_done_next  = 1'b0;
      acc_if.load   = 1'b0;
      acc_if.count  = '0;
      cyc_if.load   = 1'b0;
      cyc_if.count  = '0;
      unique case (state_reg)
         ST_IDLE: begin
            if (take) begin
               addr_next    = cmd_addr;
               dq_out_next  = cmd_wdata;
               keep_next    = cmd_keep;
               row_next     = cmd_addr[`NVSP_ADDR_W-1:`NVSP_ROW_LSB];
               acc_cnt_next = `NVSP_CNT_W'(`NVSP_CE_ACC_CYC);
               if (!cmd_write) begin
                  // strobe stays high at the select edge, so this is a read
                  cs_n_next    = 1'b0;
                  oe_n_next    = 1'b0;
                  acc_if.load  = 1'b1;
                  acc_if.count = `NVSP_CNT_W'(`NVSP_CE_ACC_CYC);
                  cyc_if.load  = 1'b1;
                  cyc_if.count = `NVSP_CNT_W'(`NVSP_RC_CYC);
                  state_next   = ST_RD_WAIT;
               end else if (cmd_ce_write) begin
                  // strobe low before select: memory starts as a write
                  we_n_next  = 1'b0;
                  dq_oe_next = 1'b1;
                  state_next = ST_CEW_ARM;
               end else begin
                  // output drive left high so the read start never drives
                  cs_n_next    = 1'b0;
                  cyc_if.load  = 1'b1;
                  cyc_if.count = `NVSP_CNT_W'(`NVSP_WC_CYC);
                  state_next   = ST_WR_ARM;
               end
            end
         end
         ST_RD_WAIT: begin
            if (acc_if.done) begin
               rd_data_next  = data_lines_in;
               rd_valid_next = 1'b1;
               oe_n_next     = 1'b1;
               state_next    = ST_HOLD;
            end
         end
         ST_WR_ARM: begin
            // one fresh strobe pulse per byte; data driven only while drive is off
            we_n_next    = 1'b0;
            dq_oe_next   = oe_n_reg;
            acc_if.load  = 1'b1;
            acc_if.count = acc_cnt_reg;
            state_next   = ST_WR_LOW;
         end
         ST_WR_LOW: begin
            // rising strobe after the access time commits the byte
            if (acc_if.done) begin
               we_n_next  = 1'b1;
               state_next = ST_WR_END;
            end
         end
         ST_WR_END: begin
            // data held one cycle past the rising strobe as hold margin
            dq_oe_next   = 1'b0;
            wr_done_next = 1'b1;
            state_next   = ST_HOLD;
         end
         ST_HOLD: begin
            if (cyc_if.done) begin
               if (keep_reg) begin
                  state_next = ST_SEL;
               end else begin
                  // select only during accesses keeps the memory in standby
                  cs_n_next    = 1'b1;
                  acc_if.load  = 1'b1;
                  acc_if.count = `NVSP_CNT_W'(`NVSP_PC_CYC);
                  state_next   = ST_PRE;
               end
            end
         end
         ST_SEL: begin
            if (take) begin
               // next access with select still low: page hit or new row
               addr_next    = cmd_addr;
               dq_out_next  = cmd_wdata;
               keep_next    = cmd_keep;
               row_next     = cmd_addr[`NVSP_ADDR_W-1:`NVSP_ROW_LSB];
               acc_cnt_next = hit_acc;
               cyc_if.load  = 1'b1;
               cyc_if.count = hit_cyc;
               if (!cmd_write) begin
                  oe_n_next    = 1'b0;
                  acc_if.load  = 1'b1;
                  acc_if.count = hit_acc;
                  state_next   = ST_RD_WAIT;
               end else begin
                  state_next = ST_WR_ARM;
               end
            end else if (cmd_release) begin
               cs_n_next    = 1'b1;
               acc_if.load  = 1'b1;
               acc_if.count = `NVSP_CNT_W'(`NVSP_PC_CYC);
               state_next   = ST_PRE;
            end
         end
         ST_PRE: begin
            // select stays high for pre-charge and the rest of the cycle time
            if (acc_if.done && cyc_if.done) begin
               state_next = ST_IDLE;
            end
         end
         ST_CEW_ARM: begin
            cs_n_next    = 1'b0;
            acc_if.load  = 1'b1;
            acc_if.count = `NVSP_CNT_W'(`NVSP_CE_ACC_CYC);
            cyc_if.load  = 1'b1;
            cyc_if.count = `NVSP_CNT_W'(`NVSP_WC_CYC);
            state_next   = ST_CEW_LOW;
         end
         ST_CEW_LOW: begin
            // select rises first, so it ends the write and starts pre-charge
            if (acc_if.done) begin
               cs_n_next    = 1'b1;
               acc_if.load  = 1'b1;
               acc_if.count = `NVSP_CNT_W'(`NVSP_PC_CYC);
               state_next   = ST_CEW_END;
            end
         end
         ST_CEW_END: begin
            we_n_next    = 1'b1;
            dq_oe_next   = 1'b0;
            wr_done_next = 1'b1;
            state_next   = ST_PRE;
         end
      endcase
      ready_next = (state_next == ST_IDLE) || (state_next == ST_SEL);
   end

   // strobe and select come out of reset high and stay so until a command
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg    <= ST_IDLE;
         cs_n_reg     <= `NVSP_PIN_RST;
         we_n_reg     <= `NVSP_PIN_RST;
         oe_n_reg     <= `NVSP_PIN_RST;
         addr_reg     <= '0;
         dq_out_reg   <= `NVSP_DATA_RST;
         dq_oe_reg    <= 1'b0;
         ready_reg    <= 1'b0;
         rd_valid_reg <= 1'b0;
         rd_data_reg  <= `NVSP_DATA_RST;
         wr_done_reg  <= 1'b0;
         keep_reg     <= 1'b0;
         row_reg      <= '0;
         acc_cnt_reg  <= '0;
      end else begin
         state_reg    <= state_next;
         cs_n_reg     <= cs_n_next;
         we_n_reg     <= we_n_next;
         oe_n_reg     <= oe_n_next;
         addr_reg     <= addr_next;
         dq_out_reg   <= dq_out_next;
         dq_oe_reg    <= dq_oe_next;
         ready_reg    <= ready_next;
         rd_valid_reg <= rd_valid_next;
         rd_data_reg  <= rd_data_next;
         wr_done_reg  <= wr_done_next;
         keep_reg     <= keep_next;
         row_reg      <= row_next;
         acc_cnt_reg  <= acc_cnt_next;
      end
   end

   assign cmd_ready      = ready_reg;
   assign rd_valid       = rd_valid_reg;
   assign rd_data        = rd_data_reg;
   assign wr_done        = wr_done_reg;
   assign chip_select_n  = cs_n_reg;
   assign write_strobe_n = we_n_reg;
   assign output_drive_n = oe_n_reg;
   assign mem_addr       = addr_reg;
   assign data_lines_out = dq_out_reg;
   assign data_lines_oe  = dq_oe_reg;

endmodule

// >>> verif/nvsp_mem_model.sv
`timescale 1ns/1ps
`include "nvsp_regs.svh"
module nvsp_mem_model
   import nvsp_pkg::*;
(
   // memory pins
   input  wire logic       chip_select_n,
   input  wire logic       write_strobe_n,
   input  wire logic       output_drive_n,
   input  wire nvsp_addr_t mem_addr,
   input  wire nvsp_data_t dq,
   output nvsp_data_t      dout,
   output logic            doe,
   // host timing faults seen
   output int              bad
);
   nvsp_data_t mem [0:32767];
   nvsp_row_t  row_reg;
   nvsp_addr_t wr_addr;
   realtime    t_ok, t_fall, t_rise, t_open, t_a;
   logic       rdy, wr_act;
   int         row_opens;
   initial begin
      for (int i = 0; i < 32768; i++) mem[i] = 8'h00;
      rdy = 1'b0;
      wr_act = 1'b0;
      bad = 0;
      row_opens = 0;
      t_rise = -1.0e6;
      t_open = -1.0e6;
   end
   always @(negedge chip_select_n) begin
      if ($realtime - t_rise < `NVSP_T_PC_NS) bad++;
      t_fall = $realtime;
      t_open = $realtime;
      rdy = 1'b0;
      t_ok = $realtime + `NVSP_T_CE_ACC_NS;
      // pins launched on one clock edge settle in any order; latch once they have
      #1;
      row_reg = mem_addr[14:3];
      row_opens++;
      if (!write_strobe_n) begin
         wr_act = 1'b1;
         wr_addr = mem_addr;
      end
   end
   // a change landing with the select edge is handled there, not as a row change
   always @(mem_addr) begin
      t_a = $realtime;
      #1;
      if (!chip_select_n && t_a != t_fall) begin
         rdy = 1'b0;
         if (mem_addr[14:3] != row_reg) begin
            if (t_a - t_open < `NVSP_T_RC_NS) bad++;
            t_open = t_a;
            row_reg = mem_addr[14:3];
            row_opens++;
            t_ok = t_a + `NVSP_T_AA_NS;
         end else begin
            t_ok = t_a + `NVSP_T_PAGE_ACC_NS;
         end
      end
   end
   // polled so a newer access always wins over an older one
   always #5 rdy = !chip_select_n && ($realtime >= t_ok);
   assign dout = mem[mem_addr];
   assign doe = rdy && write_strobe_n && !output_drive_n;
   always @(negedge write_strobe_n) begin
      if (!chip_select_n) begin
         wr_act = 1'b1;
         wr_addr = mem_addr;
      end
   end
   always @(posedge write_strobe_n or posedge chip_select_n) begin
      if (wr_act) begin
         if ($realtime < t_ok) bad++;
         mem[wr_addr] = dq;
         wr_act = 1'b0;
      end
   end
   always @(posedge chip_select_n) t_rise = $realtime;
endmodule

// >>> verif/nvsp_host_assertions.sv
`timescale 1ns/1ps
module nvsp_host_assertions
   import nvsp_pkg::*;
(
   // clock and reset
   input wire logic       clock,
   input wire logic       nrst,
   // command and results
   input wire logic       cmd_valid,
   input wire logic       rd_valid,
   input wire logic       wr_done,
   // memory pins
   input wire logic       chip_select_n,
   input wire logic       write_strobe_n,
   input wire logic       output_drive_n,
   input wire nvsp_addr_t mem_addr,
   input wire nvsp_data_t data_lines_out,
   input wire logic       data_lines_oe
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   sequence s_strobe_low; (!write_strobe_n)[*3]; endsequence
   sequence s_select_idle; chip_select_n[*3]; endsequence
   property p_strobe_len; $fell(write_strobe_n) && !chip_select_n |-> s_strobe_low; endproperty
   a_strobe_len: assert property (p_strobe_len) else $error("strobe pulse short");
   property p_data_hold;
      !write_strobe_n && !chip_select_n |=> data_lines_oe && $stable(data_lines_out);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("write data moved");
   property p_read_time; $fell(chip_select_n) && !output_drive_n |-> ##4 rd_valid; endproperty
   a_read_time: assert property (p_read_time) else $error("read result late");
   property p_one_pulse;
      wr_done |-> $rose(write_strobe_n) || ($past(write_strobe_n) && !$past(write_strobe_n, 2));
   endproperty
   a_one_pulse: assert property (p_one_pulse) else $error("write without pulse");
   property p_page_addr; !write_strobe_n && $past(!write_strobe_n) |-> $stable(mem_addr); endproperty
   a_page_addr: assert property (p_page_addr) else $error("address moved in write");
   property p_precharge; $rose(chip_select_n) |-> s_select_idle; endproperty
   a_precharge: assert property (p_precharge) else $error("precharge short");
   property p_cycle; $fell(chip_select_n) |=> (!$fell(chip_select_n))[*4]; endproperty
   a_cycle: assert property (p_cycle) else $error("cycle time short");
   property p_reset_pins; $rose(nrst) |-> write_strobe_n && chip_select_n; endproperty
   a_reset_pins: assert property (p_reset_pins) else $error("strobe low at reset");
   property p_demand; $fell(chip_select_n) |-> $past(cmd_valid) || $past(cmd_valid, 2); endproperty
   a_demand: assert property (p_demand) else $error("select without request");
   property p_no_fight; data_lines_oe |-> output_drive_n; endproperty
   a_no_fight: assert property (p_no_fight) else $error("bus contention");
endmodule
bind nvsp_host nvsp_host_assertions i_nvsp_host_assertions (.clock(clock), .nrst(nrst),
   .cmd_valid(cmd_valid), .rd_valid(rd_valid), .wr_done(wr_done),
   .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
   .output_drive_n(output_drive_n), .mem_addr(mem_addr),
   .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe));

// >>> verif/nvsp_host_bench.sv
`timescale 1ns/1ps
module nvsp_host_bench
   import nvsp_pkg::*;
();
   logic       clock, nrst, cmd_valid, cmd_write, cmd_ce_write, cmd_keep, cmd_release;
   logic       cmd_ready, rd_valid, wr_done, chip_select_n, write_strobe_n, output_drive_n;
   logic       data_lines_oe, mem_oe;
   nvsp_addr_t cmd_addr, mem_addr, a;
   nvsp_data_t cmd_wdata, rd_data, data_lines_out, mem_dout, dq_last, d;
   wire nvsp_data_t dq;
   int         num_errors, checks_done, seed, r, mem_bad, i;
   int         ref_mem [int];
   nvsp_host i_nvsp_host (.clock(clock), .nrst(nrst), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_ce_write(cmd_ce_write), .cmd_keep(cmd_keep),
      .cmd_release(cmd_release), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_data(rd_data), .wr_done(wr_done),
      .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
      .output_drive_n(output_drive_n), .mem_addr(mem_addr), .data_lines_in(dq),
      .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe));
   nvsp_mem_model i_nvsp_mem_model (.chip_select_n(chip_select_n),
      .write_strobe_n(write_strobe_n), .output_drive_n(output_drive_n), .mem_addr(mem_addr),
      .dq(dq), .dout(mem_dout), .doe(mem_oe), .bad(mem_bad));
   // a released bus shows a changing pattern, never the last value
   assign dq = data_lines_oe ? data_lines_out : (mem_oe ? mem_dout : ~dq_last);
   always @(posedge clock) dq_last <= dq;
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task stop_test;
      $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task check(input string nm, input nvsp_data_t exp, input nvsp_data_t got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (cmd_ready !== 1'b1 && n < 100);
      if (n >= 100) check("cmd_ready", 8'h01, 8'h00);
   endtask
   task access(input logic w, input logic cew, input logic keep, input nvsp_addr_t ad,
               input nvsp_data_t wd);
      int n;
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_ce_write <= cew;
      cmd_keep <= keep;
      cmd_addr <= ad;
      cmd_wdata <= wd;
      wait_ready();
      cmd_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while ((w ? wr_done : rd_valid) !== 1'b1 && n < 100);
      if (n >= 100) check("result", 8'h01, 8'h00);
      if (w) ref_mem[ad] = wd;
      else check("rd_data", ref_mem.exists(ad) ? nvsp_data_t'(ref_mem[ad]) : 8'h00, rd_data);
   endtask
   task release_select;
      cmd_release <= 1'b1;
      wait_ready();
      cmd_release <= 1'b0;
      @(posedge clock);
   endtask
   initial begin
      repeat (5000) @(posedge clock);
      num_errors++;
      stop_test();
   end
   initial begin
      {nrst, cmd_valid, cmd_write, cmd_ce_write, cmd_keep, cmd_release} = 6'h00;
      cmd_addr = 15'h0000;
      cmd_wdata = 8'h00;
      dq_last = 8'h00;
      seed = 32'hc9d4_20f4;
      repeat (3) @(posedge clock);
      check("pins", 8'h07, {5'h00, chip_select_n, write_strobe_n, output_drive_n});
      check("outs", 8'h00, {4'h0, data_lines_oe, cmd_ready, rd_valid, wr_done});
      nrst <= 1'b1;
      repeat (2) @(posedge clock);
      for (i = 0; i < 12; i++) begin
         r = $random(seed);
         a = r[14:0];
         d = r[22:15];
         access(1'b1, i[0], 1'b0, a, d);
         access(1'b0, 1'b0, 1'b0, a, 8'h00);
      end
      r = $random(seed);
      a = {r[14:3], 3'h0};
      for (i = 0; i < 8; i++) begin
         r = $random(seed);
         access(1'b1, 1'b0, 1'b1, a | 15'(i), r[7:0]);
      end
      for (i = 7; i >= 0; i--) access(1'b0, 1'b0, 1'b1, a | 15'(i), 8'h00);
      access(1'b0, 1'b0, 1'b1, a ^ 15'h0008, 8'h00);
      access(1'b1, 1'b1, 1'b1, a ^ 15'h0010, 8'h5a);
      access(1'b0, 1'b0, 1'b1, a ^ 15'h0010, 8'h00);
      release_select();
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      repeat (2) @(posedge clock);
      access(1'b0, 1'b0, 1'b0, a | 15'h0003, 8'h00);
      check("host timing faults", 8'h00, (mem_bad > 255) ? 8'hff : 8'(mem_bad));
      // 26 select falls plus 2 row changes under a held select
      check("row opens", 8'h1c, 8'(i_nvsp_mem_model.row_opens));
      stop_test();
   end
endmodule
